//--- logic/bwsq_consts.vh
// Constants of the burst read wait sequencer.
// Assumes inclusion by bare name from logic/.
`ifndef BWSQ_CONSTS_VH
`define BWSQ_CONSTS_VH

// ====================================
// Register map (byte addresses)
// ====================================
`define BWSQ_CFG_OFS 4'h0
`define BWSQ_STS_OFS 4'h4

// ====================================
// Read configuration fields
// ====================================
`define BWSQ_RM_BIT 15
`define BWSQ_LC_HI 13
`define BWSQ_LC_LO 11
`define BWSQ_WP_BIT 10
`define BWSQ_DOC_BIT 9
`define BWSQ_WC_BIT 8
`define BWSQ_BS_BIT 7
`define BWSQ_CC_BIT 6
`define BWSQ_BW_BIT 3
`define BWSQ_BL_HI 2
`define BWSQ_BL_LO 0
`define BWSQ_CFG_RESET 16'hBFCF
`define BWSQ_CFG_WMASK 16'hBFCF

// ====================================
// Burst length codes
// ====================================
`define BWSQ_BL_4 3'h1
`define BWSQ_BL_8 3'h2
`define BWSQ_BL_16 3'h3
`define BWSQ_BL_CONT 3'h7

// ====================================
// Burst geometry and timing counts
// ====================================
`define BWSQ_ROW_BITS 4
`define BWSQ_GROUP_BITS 2
`define BWSQ_DLY_BASE 4'h4
`define BWSQ_MIN_DLY 3'h1

`endif

//--- logic/bwsq_addr_gen.v
// Next burst address for linear wrap and no-wrap sequences.
// Assumes a registered current address and decoded length mask.
`timescale 1ns/1ps

module bwsq_addr_gen #(
    parameter ADDR_W = 22
) (
    input wire [ADDR_W-1:0] cur_addr_i,
    input wire [3:0] len_mask_i,
    input wire wrap_i,
    output wire [ADDR_W-1:0] next_addr_o,
    output wire row_cross_o,
    output wire last_addr_o
);

    wire [ADDR_W-1:0] inc_addr;
    wire [3:0] low_wrap;

    assign inc_addr = cur_addr_i + {{(ADDR_W-1){1'b0}}, 1'b1};
    // Low bits wrap only within the length mask
    assign low_wrap = (inc_addr[3:0] & len_mask_i) | (cur_addr_i[3:0] & ~len_mask_i);

    // ====================================
    // Per-bit select of wrapped or linear
    // ====================================
    genvar gi;
    generate
        for (gi = 0; gi < ADDR_W; gi = gi + 1) begin : g_bit
            if (gi < 4) begin : g_low
                assign next_addr_o[gi] = wrap_i ? low_wrap[gi] : inc_addr[gi];
            end else begin : g_high
                // Upper bits freeze when wrapping inside the group
                assign next_addr_o[gi] = wrap_i ? cur_addr_i[gi] : inc_addr[gi];
            end
        end
    endgenerate

    // Crossing into a new 16-word row
    assign row_cross_o = (inc_addr[3:0] == 4'h0);
    // End of burstable space
    assign last_addr_o = &cur_addr_i;

endmodule

//--- logic/bwsq_sequencer.v
// Burst read output sequencer: wait pin, data hold, burst order.
// Assumes host pins arrive asynchronously and a one-cycle array
// read on arr_addr_o; configuration is written over Wishbone.
//
// Function
// - Wait polarity follows polarity bit
// - Array sync reads: wait marks valid data
// - Sync non-array reads hold wait asserted
// - Async reads and writes hold wait asserted
// - Wait tri-stated while chip select high
// - Data hold selects one or two clocks
// - Wait during delay or cycle ahead
// - No-wrap and continuous may delay at row
// - Four-word aligned start: no row delay
// - Misaligned start: row delay at most once
// - Last-of-group start: delay latency minus one
// - Burst data in linear order only
// - Length codes 4, 8, 16, continuous
// - Wrap mode wraps within aligned group
// - No-wrap increments across group boundaries
// - Continuous burst linear, ignores wrap bit
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "bwsq_consts.vh"

module bwsq_sequencer #(
    parameter ADDR_W = 22,
    parameter DATA_W = 16
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire ce_n_i,
    input wire adv_n_i,
    input wire we_n_i,
    input wire [ADDR_W-1:0] addr_i,
    input wire array_mode_i,
    output wire [ADDR_W-1:0] arr_addr_o,
    input wire [DATA_W-1:0] arr_data_i,
    output reg [DATA_W-1:0] data_o,
    output reg wait_o,
    output reg wait_oe_n_o,
    output wire [2:0] cfg_lat_code_o,
    output wire cfg_clk_edge_o
);

    // ====================================
    // States
    // ====================================
    localparam ST_IDLE = 3'h0;
    localparam ST_LAT = 3'h1;
    localparam ST_DATA = 3'h2;
    localparam ST_BDLY = 3'h3;
    localparam ST_DONE = 3'h4;

    // ====================================
    // Pin synchronisers
    // ====================================
    reg ce_n_m;
    reg ce_n_s;
    reg adv_n_m;
    reg adv_n_s;
    reg we_n_m;
    reg we_n_s;
    reg [ADDR_W-1:0] addr_m;
    reg [ADDR_W-1:0] addr_s;

    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            ce_n_m <= 1'b1;
            ce_n_s <= 1'b1;
            adv_n_m <= 1'b1;
            adv_n_s <= 1'b1;
            we_n_m <= 1'b1;
            we_n_s <= 1'b1;
            addr_m <= {ADDR_W{1'b0}};
            addr_s <= {ADDR_W{1'b0}};
        end else begin
            ce_n_m <= ce_n_i;
            ce_n_s <= ce_n_m;
            adv_n_m <= adv_n_i;
            adv_n_s <= adv_n_m;
            we_n_m <= we_n_i;
            we_n_s <= we_n_m;
            addr_m <= addr_i;
            addr_s <= addr_m;
        end
    end

    // ====================================
    // Read configuration register
    // ====================================
    reg [15:0] read_config_reg;
    reg [2:0] state;
    reg [ADDR_W-1:0] cur_addr;
    reg crossed;
    wire sync_array;
    wire [31:0] status_word;
    wire wb_req;
    wire cfg_hit;
    wire sts_hit;
    wire [15:0] cfg_wmask;

    assign cfg_wmask = `BWSQ_CFG_WMASK;
    assign wb_req = wb_cyc_i & wb_stb_i;
    assign cfg_hit = (wb_adr_i == `BWSQ_CFG_OFS);
    assign sts_hit = (wb_adr_i == `BWSQ_STS_OFS);
    assign status_word = {cur_addr[15:0], 8'h00, 3'h0, crossed,
                          sync_array, state};

    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            read_config_reg <= `BWSQ_CFG_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req && !wb_ack_o && wb_we_i && cfg_hit) begin
                // Reserved bits stay zero
                if (wb_sel_i[0]) begin
                    read_config_reg[7:0] <= wb_dat_i[7:0] & cfg_wmask[7:0];
                end
                if (wb_sel_i[1]) begin
                    read_config_reg[15:8] <= wb_dat_i[15:8] & cfg_wmask[15:8];
                end
            end
            if (wb_req && !wb_ack_o && !wb_we_i) begin
                if (cfg_hit) begin
                    wb_dat_o <= {16'h0000, read_config_reg};
                end else if (sts_hit) begin
                    wb_dat_o <= status_word;
                end else begin
                    wb_dat_o <= 32'h00000000;
                end
            end
        end
    end

    // ====================================
    // Configuration decode
    // ====================================
    wire async_mode;
    wire [2:0] lat_code;
    wire pol_high;
    wire hold_two;
    wire wait_early;
    wire no_wrap;
    wire [2:0] len_code;
    reg [3:0] len_mask;
    reg continuous;

    assign async_mode = read_config_reg[`BWSQ_RM_BIT];
    assign lat_code = read_config_reg[`BWSQ_LC_HI:`BWSQ_LC_LO];
    assign pol_high = read_config_reg[`BWSQ_WP_BIT];
    assign hold_two = read_config_reg[`BWSQ_DOC_BIT];
    assign wait_early = read_config_reg[`BWSQ_WC_BIT];
    assign no_wrap = read_config_reg[`BWSQ_BW_BIT];
    assign len_code = read_config_reg[`BWSQ_BL_HI:`BWSQ_BL_LO];
    assign cfg_lat_code_o = lat_code;
    assign cfg_clk_edge_o = read_config_reg[`BWSQ_CC_BIT];

    always @* begin
        len_mask = 4'hF;
        continuous = 1'b0;
        case (len_code)
            `BWSQ_BL_4: len_mask = 4'h3;
            `BWSQ_BL_8: len_mask = 4'h7;
            `BWSQ_BL_16: len_mask = 4'hF;
            `BWSQ_BL_CONT: continuous = 1'b1;
            default: continuous = 1'b1;
        endcase
    end

    // Continuous bursts never wrap
    wire wrap_sel;
    assign wrap_sel = ~no_wrap & ~continuous;

    // Synchronous array read: the only case wait carries meaning
    assign sync_array = ~async_mode & array_mode_i & we_n_s & ~ce_n_s;

    // ====================================
    // Address generator
    // ====================================
    wire [ADDR_W-1:0] next_addr;
    wire row_cross;
    wire last_addr;

    // Linear order always; the sequence bit is writable but never read
    bwsq_addr_gen #(
        .ADDR_W(ADDR_W)
    ) u_addr_gen (
        .cur_addr_i(cur_addr),
        .len_mask_i(len_mask),
        .wrap_i(wrap_sel),
        .next_addr_o(next_addr),
        .row_cross_o(row_cross),
        .last_addr_o(last_addr)
    );

    assign arr_addr_o = cur_addr;

    // ====================================
    // Row boundary delay length
    // ====================================
    reg [2:0] row_dly;
    reg [3:0] dly_sum;
    reg row_dly_en;

    always @* begin
        dly_sum = {1'b0, lat_code} + {2'h0, addr_s[1:0]};
        row_dly = `BWSQ_MIN_DLY;
        if (dly_sum > `BWSQ_DLY_BASE) begin
            // Offset 3 gives latency minus one
            row_dly = dly_sum[2:0] - 3'h4;
        end
        // Aligned start never delays; wrap bursts never cross
        row_dly_en = (addr_s[1:0] != 2'h0) & ~wrap_sel;
    end

    // ====================================
    // Burst sequencer
    // ====================================
    reg [2:0] cnt;
    reg hold_cnt;
    reg [4:0] words;
    reg [2:0] dly_len;
    reg dly_en;
    reg start_d;
    wire start;
    wire last_hold;
    wire burst_end;
    wire will_delay;

    assign start = sync_array & ~adv_n_s;
    assign last_hold = hold_two ? hold_cnt : 1'b1;
    assign burst_end = continuous ? last_addr
                     : (words == {1'b0, len_mask});
    assign will_delay = row_cross & dly_en & ~crossed;

    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state <= ST_IDLE;
            cur_addr <= {ADDR_W{1'b0}};
            cnt <= 3'h0;
            hold_cnt <= 1'b0;
            words <= 5'h00;
            crossed <= 1'b0;
            dly_len <= `BWSQ_MIN_DLY;
            dly_en <= 1'b0;
            start_d <= 1'b0;
        end else begin
            start_d <= start;
            if (!sync_array) begin
                state <= ST_IDLE;
            end else if (start) begin
                // New address restarts the burst
                state <= ST_LAT;
                cur_addr <= addr_s;
                cnt <= lat_code - 3'h1;
                hold_cnt <= 1'b0;
                words <= 5'h00;
                crossed <= 1'b0;
                dly_len <= row_dly;
                dly_en <= row_dly_en;
            end else begin
                case (state)
                    ST_LAT: begin
                        if (cnt <= 3'h1) begin
                            state <= ST_DATA;
                        end else begin
                            cnt <= cnt - 3'h1;
                        end
                    end
                    ST_DATA: begin
                        hold_cnt <= ~last_hold;
                        if (last_hold) begin
                            words <= words + 5'h01;
                            if (burst_end) begin
                                state <= ST_DONE;
                            end else begin
                                cur_addr <= next_addr;
                                if (will_delay) begin
                                    crossed <= 1'b1;
                                    cnt <= dly_len;
                                    state <= ST_BDLY;
                                end
                            end
                        end
                    end
                    ST_BDLY: begin
                        // No advance while not ready
                        if (cnt <= 3'h1) begin
                            state <= ST_DATA;
                        end else begin
                            cnt <= cnt - 3'h1;
                        end
                    end
                    ST_DONE: begin
                        state <= ST_DONE;
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ====================================
    // Wait and data outputs
    // ====================================
    reg not_ready;

    always @* begin
        not_ready = 1'b1;
        if (sync_array && !start && !start_d) begin
            not_ready = (state != ST_DATA);
            if (state == ST_DATA && wait_early && will_delay
                && last_hold && !burst_end) begin
                // Flag the row delay one data cycle ahead
                not_ready = 1'b1;
            end
        end
    end

    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            wait_o <= 1'b1;
            wait_oe_n_o <= 1'b1;
            data_o <= {DATA_W{1'b0}};
        end else begin
            wait_o <= pol_high ? not_ready : ~not_ready;
            // Driven only while chip select low; output enable ignored
            wait_oe_n_o <= ce_n_s;
            if (state == ST_DATA) begin
                data_o <= arr_data_i;
            end
        end
    end

endmodule

//--- dv/bwsq_array_model.sv
// Array model for the burst read wait sequencer.
// Assumes one read address per clock, answered in the same cycle.
`timescale 1ns/1ps

module bwsq_array_model #(
    parameter ADDR_W = 22,
    parameter DATA_W = 16
) (
    input wire [ADDR_W-1:0] addr_i,
    output wire [DATA_W-1:0] data_o
);
    // Distinct word per address so skips and repeats show
    assign data_o = addr_i[DATA_W-1:0] ^ 16'h5A5A;
endmodule

//--- dv/bwsq_sequencer_assertions.sv
// Port checker for the burst read wait sequencer.
// Assumes the configuration is shadowed from Wishbone writes.
`timescale 1ns/1ps
`include "bwsq_consts.vh"

module bwsq_seq_checker #(
    parameter ADDR_W = 22,
    parameter DATA_W = 16
) (
    input wire sys_clk_i,
    input wire reset_n_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    input wire ce_n_i,
    input wire we_n_i,
    input wire array_mode_i,
    input wire [DATA_W-1:0] data_o,
    input wire wait_o,
    input wire wait_oe_n_o
);
    // ====================================
    // Configuration shadow
    // ====================================
    reg [15:0] cfg;
    reg [15:0] cfg_q;
    wire [15:0] msk = `BWSQ_CFG_WMASK;
    wire stab = cfg == cfg_q;
    wire rdy = stab && !wait_oe_n_o && wait_o != cfg[`BWSQ_WP_BIT];
    always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            cfg <= `BWSQ_CFG_RESET;
            cfg_q <= `BWSQ_CFG_RESET;
        end else begin
            cfg_q <= cfg;
            if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `BWSQ_CFG_OFS) begin
                if (wb_sel_i[0]) cfg[7:0] <= wb_dat_i[7:0] & msk[7:0];
                if (wb_sel_i[1]) cfg[15:8] <= wb_dat_i[15:8] & msk[15:8];
            end
        end
    end

    // ====================================
    // Properties
    // ====================================
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_OE_IDLE: assert property (ce_n_i [*5] |-> wait_oe_n_o)
        else $error("wait driven while deselected");
    AST_OE_SEL: assert property (!ce_n_i [*5] |-> !wait_oe_n_o)
        else $error("wait not driven while selected");
    AST_ASYNC_LVL: assert property (stab && cfg[15] |-> wait_o == cfg[10])
        else $error("wait not asserted in async mode");
    AST_WRITE_LVL: assert property (!we_n_i [*4] ##0 stab |-> wait_o == cfg[10])
        else $error("wait not asserted in write cycle");
    AST_NONARRAY_LVL: assert property (!array_mode_i [*2] ##0 stab |-> wait_o == cfg[10])
        else $error("wait not asserted in non-array read");
    AST_READY_SYNC: assert property (rdy |-> !cfg[15] && $past(array_mode_i))
        else $error("ready outside sync array read");
    AST_HOLD_TWO: assert property (rdy && cfg[9] && data_o != $past(data_o) |=> $stable(data_o))
        else $error("word held one clock in two-clock mode");
    AST_HOLD_ONE: assert property (rdy && $past(rdy) && !cfg[9] |-> data_o != $past(data_o))
        else $error("word repeated in one-clock mode");
    AST_COV_READY: cover property (rdy);
    AST_COV_READY_TWO: cover property (rdy && cfg[9]);
    AST_COV_SYNC_SEL: cover property (!wait_oe_n_o && !cfg[15]);
endmodule

bind bwsq_sequencer bwsq_seq_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) bwsq_seq_checker_i (
    .sys_clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .ce_n_i, .we_n_i, .array_mode_i, .data_o, .wait_o, .wait_oe_n_o
);

//--- dv/bwsq_sequencer_tb_top.sv
// Testbench for the burst read wait sequencer.
// Assumes the array model on the array side and Wishbone configuration.
`timescale 1ns/1ps
`include "bwsq_consts.vh"

module bwsq_sequencer_tb_top;
    reg sys_clk_i = 1'b0;
    reg reset_n_i = 1'b0;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [3:0] wb_adr_i = 4'h0;
    reg [3:0] wb_sel_i = 4'h0;
    reg [31:0] wb_dat_i = 32'h0;
    reg ce_n_i = 1'b1;
    reg adv_n_i = 1'b1;
    reg we_n_i = 1'b1;
    reg array_mode_i = 1'b1;
    reg [21:0] addr_i = 22'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [21:0] arr_addr_o;
    wire [15:0] arr_data_i;
    wire [15:0] data_o;
    wire wait_o;
    wire wait_oe_n_o;
    wire [2:0] cfg_lat_code_o;
    wire cfg_clk_edge_o;
    integer miscompares = 0;
    integer total_checks = 0;
    integer gaps;
    reg [31:0] rd;
    reg [15:0] cfg;
    reg [15:0] last;

    bwsq_sequencer bwsq_sequencer_i (.*);
    bwsq_array_model bwsq_array_model_i (.addr_i(arr_addr_o), .data_o(arr_data_i));

    // ====================================
    // Shared tasks
    // ====================================
    task chk(input [8*12-1:0] name, input [31:0] exp, input [31:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("Error %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    task wb(input we, input [3:0] adr, input [31:0] wd);
        begin
            @(posedge sys_clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= adr;
            wb_sel_i <= 4'hF;
            wb_dat_i <= wd;
            @(posedge sys_clk_i);
            while (wb_ack_o !== 1'b1) begin
                @(posedge sys_clk_i);
            end
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge sys_clk_i);
            chk("wb_ack", 0, wb_ack_o);
        end
    endtask

    task setcfg(input rm, input data_hold_select, input wc, input wp, input bw, input [2:0] bl);
        begin
            cfg = {rm, 1'b0, 3'h3, wp, data_hold_select, wc, 4'hC, bw, bl};
            wb(1'b1, `BWSQ_CFG_OFS, {16'h0, cfg});
        end
    endtask

    task burst(input [21:0] a, input integer n, input integer len);
        integer k;
        integer t;
        reg [21:0] e;
        integer x;
        begin
            k = 0;
            t = 0;
            gaps = 0;
            @(posedge sys_clk_i);
            ce_n_i <= 1'b0;
            addr_i <= a;
            adv_n_i <= 1'b0;
            @(posedge sys_clk_i);
            adv_n_i <= 1'b1;
            while (k < n && t < 300) begin
                @(posedge sys_clk_i);
                #1;
                t = t + 1;
                if (wait_o !== cfg[10] && (k == 0 || data_o !== last)) begin
                    e = (cfg[3] || len == 0) ? a + k : (a & ~(len - 1)) | ((a + k) & (len - 1));
                    chk("burst_word", e[15:0] ^ 16'h5A5A, data_o);
                    last = data_o;
                    k = k + 1;
                end else if (k > 0 && wait_o === cfg[10]) begin
                    gaps = gaps + 1;
                end
            end
            chk("word_count", n, k);
            x = 0;
            repeat (4) begin
                @(posedge sys_clk_i);
                #1;
                if (wait_o !== cfg[10] && data_o !== last) x = x + 1;
            end
            if (len != 0) chk("extra_words", 0, x);
            if (len != 0) chk("burst_end", cfg[10], wait_o);
            @(posedge sys_clk_i);
            ce_n_i <= 1'b1;
            repeat (6) @(posedge sys_clk_i);
        end
    endtask

    // ====================================
    // Scenarios
    // ====================================
    task t_reset;
        begin
            wb(1'b0, `BWSQ_CFG_OFS, 0);
            chk("cfg_reset", `BWSQ_CFG_RESET, rd);
            wb(1'b1, 4'h8, 32'hFFFF);
            wb(1'b0, 4'h8, 0);
            chk("unmapped", 0, rd);
            chk("lat_code", 3'h7, cfg_lat_code_o);
            chk("clk_edge", 1, cfg_clk_edge_o);
            chk("oe_idle", 1, wait_oe_n_o);
        end
    endtask

    task t_async;
        begin
            setcfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h1);
            @(posedge sys_clk_i);
            ce_n_i <= 1'b0;
            adv_n_i <= 1'b0;
            repeat (6) @(posedge sys_clk_i);
            #1;
            chk("async_wait", 0, wait_o);
            chk("oe_sel", 0, wait_oe_n_o);
            @(posedge sys_clk_i);
            ce_n_i <= 1'b1;
            adv_n_i <= 1'b1;
            repeat (5) @(posedge sys_clk_i);
            #1;
            chk("oe_desel", 1, wait_oe_n_o);
        end
    endtask

    task t_modes;
        begin
            setcfg(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1);
            @(posedge sys_clk_i);
            array_mode_i <= 1'b0;
            ce_n_i <= 1'b0;
            adv_n_i <= 1'b0;
            @(posedge sys_clk_i);
            adv_n_i <= 1'b1;
            repeat (10) @(posedge sys_clk_i);
            #1;
            chk("nonarray", 1, wait_o);
            @(posedge sys_clk_i);
            array_mode_i <= 1'b1;
            we_n_i <= 1'b0;
            repeat (6) @(posedge sys_clk_i);
            #1;
            chk("write_wait", 1, wait_o);
            @(posedge sys_clk_i);
            we_n_i <= 1'b1;
            ce_n_i <= 1'b1;
            repeat (6) @(posedge sys_clk_i);
        end
    endtask

    task run(input [21:0] a, input integer n, input integer len, input [2:0] bl,
             input bw, input data_hold_select, input wc, input wp, input integer gx);
        begin
            // Host picks hold mode for its own setup margin
            setcfg(1'b0, data_hold_select, wc, wp, bw, bl);
            burst(a, n, len);
            chk("row_delay", gx, gaps);
        end
    endtask

    task t_bursts;
        begin
            run(22'h1, 4, 4, `BWSQ_BL_4, 1'b0, 1'b0, 1'b0, 1'b1, 0);
            run(22'h3, 4, 4, `BWSQ_BL_4, 1'b1, 1'b1, 1'b1, 1'b0, 0);
            run(22'h5, 8, 8, `BWSQ_BL_8, 1'b0, 1'b0, 1'b1, 1'b1, 0);
            run(22'hE, 16, 16, `BWSQ_BL_16, 1'b0, 1'b1, 1'b0, 1'b0, 0);
            run(22'h4, 16, 16, `BWSQ_BL_16, 1'b1, 1'b0, 1'b0, 1'b1, 0);
            run(22'h3, 20, 0, `BWSQ_BL_CONT, 1'b0, 1'b0, 1'b0, 1'b1, 2);
            run(22'hD, 24, 0, `BWSQ_BL_CONT, 1'b1, 1'b0, 1'b0, 1'b0, 1);
            run(22'h1B, 12, 0, `BWSQ_BL_CONT, 1'b1, 1'b1, 1'b1, 1'b0, 3);
        end
    endtask

    task close_out;
        begin
            $display("checks %0d miscompares %0d", total_checks, miscompares);
            if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        #500000;
        miscompares = miscompares + 1;
        close_out;
    end

    initial begin
        repeat (10) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_reset;
        t_async;
        t_modes;
        t_bursts;
        close_out;
    end
endmodule
